// ===== core/twm_slave.sv
`timescale 1ns/10ps
`include "twm_defs.svh"

module twm_slave
    import twm_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = `TWM_DEV_TYPE_DFLT,
    parameter int         AW       = `TWM_MEM_AW,
    parameter int         DW       = `TWM_DATA_W
) (
    // system clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  RESET_N,
    input  wire logic                  CLK_EN,
    // two-wire bus, SCL is also the link clock
    input  wire logic                  SCL,
    input  wire logic                  SDA_I,
    output logic                       SDA_O,
    output logic                       SDA_OE,
    // strap pins
    input  wire logic                  WRITE_PROTECT,
    input  wire logic [`TWM_SEL_W-1:0] DEVICE_SELECT_PINS
);

    // ------------------------------------------------------------------
    // pin synchronisers and glitch filter
    // ------------------------------------------------------------------
    logic [`TWM_PIN_W-1:0] pin_raw;
    logic [`TWM_PIN_W-1:0] pin_s1;
    logic [`TWM_PIN_W-1:0] pin_s2;
    logic [`TWM_PIN_W-1:0] pin_s3;
    logic [`TWM_PIN_W-1:0] pin_f;
    logic [`TWM_PIN_W-1:0] next_pin_f;
    logic [`TWM_PIN_W-1:0] pin_agree;

    // pull-downs are outside; a floating pin arrives here as low
    assign pin_raw = {DEVICE_SELECT_PINS, WRITE_PROTECT, SCL, SDA_I};

    // a bit moves only when stages two and three agree
    always_comb begin
        pin_agree  = ~(pin_s2 ^ pin_s3);
        next_pin_f = (pin_s2 & pin_agree) | (pin_f & ~pin_agree);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_s1 <= `TWM_PIN_IDLE;
            pin_s2 <= `TWM_PIN_IDLE;
            pin_s3 <= `TWM_PIN_IDLE;
            pin_f  <= `TWM_PIN_IDLE;
        end else if (CLK_EN) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= next_pin_f;
        end
    end

    // ------------------------------------------------------------------
    // bus condition decode
    // ------------------------------------------------------------------
    logic                  sda;
    logic                  scl;
    logic                  wp;
    logic [`TWM_SEL_W-1:0] sel;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_ev;
    logic                  stop_ev;

    assign sda = pin_f[`TWM_PIN_SDA];
    assign scl = pin_f[`TWM_PIN_SCL];
    assign wp  = pin_f[`TWM_PIN_WP];
    assign sel = pin_f[`TWM_PIN_SEL_HI:`TWM_PIN_SEL_LO];

    // SDA moving with SCL high is START or STOP, else data or ack
    assign scl_rise = next_pin_f[`TWM_PIN_SCL] & ~scl;
    assign scl_fall = ~next_pin_f[`TWM_PIN_SCL] & scl;
    assign start_ev = scl & next_pin_f[`TWM_PIN_SCL] & sda & ~next_pin_f[`TWM_PIN_SDA];
    assign stop_ev  = scl & next_pin_f[`TWM_PIN_SCL] & ~sda & next_pin_f[`TWM_PIN_SDA];

    // ------------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------------
    twm_state_type state;
    twm_state_type next_state;
    twm_phase_type phase;
    twm_phase_type next_phase;
    logic [2:0]    bit_cnt;
    logic [2:0]    next_bit_cnt;
    logic [DW-1:0] rx_sreg;
    logic [DW-1:0] next_rx_sreg;
    logic [DW-1:0] tx_sreg;
    logic [DW-1:0] next_tx_sreg;
    logic [AW-1:0] addr;
    logic [AW-1:0] next_addr;
    logic [AW-1:0] waddr;
    logic [AW-1:0] next_waddr;
    logic          rw;
    logic          next_rw;
    logic          drive;
    logic          next_drive;
    logic          allow;
    logic          next_allow;
    logic          mem_we;
    logic          next_mem_we;
    logic [DW-1:0] rdata;
    logic          sel_match;

    assign sel_match = (next_rx_sreg[`TWM_TYPE_HI:`TWM_TYPE_LO] == DEV_TYPE) &&
                       (next_rx_sreg[`TWM_SEL_HI:`TWM_SEL_LO] == sel);

    always_comb begin
        next_state   = state;
        next_phase   = phase;
        next_bit_cnt = bit_cnt;
        next_rx_sreg = rx_sreg;
        next_tx_sreg = tx_sreg;
        next_addr    = addr;
        next_waddr   = waddr;
        next_rw      = rw;
        next_drive   = drive;
        next_allow   = allow;
        next_mem_we  = 1'b0;
        if (start_ev) begin
            // restart from the slave address, whatever was going on
            next_state   = ST_RX;
            next_phase   = PH_DEV;
            next_bit_cnt = 3'h0;
            next_drive   = 1'b0;
            next_allow   = 1'b0;
        end else if (stop_ev) begin
            next_state = ST_IDLE;
            next_drive = 1'b0;
            next_allow = 1'b0;
        end else begin
            // output gate reopens once the link stage has seen a fall
            if (scl_fall) begin
                next_allow = 1'b1;
            end
            if (scl_rise) begin
                case (state)
                    ST_RX: begin
                        next_rx_sreg = {rx_sreg[DW-2:0], sda};
                        next_bit_cnt = 3'(bit_cnt + 3'h1);
                        if (bit_cnt == `TWM_LAST_BIT) begin
                            next_bit_cnt = 3'h0;
                            next_state   = ST_ACK;
                            next_drive   = 1'b1;
                            case (phase)
                                PH_DEV: begin
                                    if (sel_match) begin
                                        next_rw = next_rx_sreg[`TWM_RW_BIT];
                                    end else begin
                                        next_state = ST_IDLE;
                                        next_drive = 1'b0;
                                    end
                                end
                                PH_AHI: begin
                                    // top address bit is dropped
                                    next_addr = {next_rx_sreg[AW-DW-1:0], addr[DW-1:0]};
                                end
                                PH_ALO: begin
                                    next_addr = {addr[AW-1:DW], next_rx_sreg};
                                end
                                default: begin
                                    if (wp) begin
                                        // protected: no ack, no write, no increment
                                        next_state = ST_IDLE;
                                        next_drive = 1'b0;
                                    end else begin
                                        next_mem_we = 1'b1;
                                        next_waddr  = addr;
                                        next_addr   = addr + `TWM_ADDR_ONE;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (phase == PH_DEV && rw) begin
                            next_state   = ST_TX;
                            next_tx_sreg = rdata;
                            next_drive   = ~rdata[DW-1];
                        end else begin
                            next_state = ST_RX;
                            next_drive = 1'b0;
                            case (phase)
                                PH_DEV:  next_phase = PH_AHI;
                                PH_AHI:  next_phase = PH_ALO;
                                default: next_phase = PH_DATA;
                            endcase
                        end
                    end
                    ST_TX: begin
                        next_tx_sreg = {tx_sreg[DW-2:0], 1'b0};
                        next_bit_cnt = 3'(bit_cnt + 3'h1);
                        if (bit_cnt == `TWM_LAST_BIT) begin
                            // release for the master's acknowledge
                            next_bit_cnt = 3'h0;
                            next_state   = ST_MACK;
                            next_drive   = 1'b0;
                            next_addr    = addr + `TWM_ADDR_ONE;
                        end else begin
                            next_drive = ~next_tx_sreg[DW-1];
                        end
                    end
                    ST_MACK: begin
                        if (!sda) begin
                            next_state   = ST_TX;
                            next_tx_sreg = rdata;
                            next_drive   = ~rdata[DW-1];
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                    default: begin
                        next_state = state;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            state   <= ST_IDLE;
            phase   <= PH_DEV;
            bit_cnt <= 3'h0;
            rx_sreg <= '0;
            tx_sreg <= '0;
            addr    <= `TWM_ADDR_RST;
            waddr   <= `TWM_ADDR_RST;
            rw      <= 1'b0;
            drive   <= 1'b0;
            allow   <= 1'b0;
            mem_we  <= 1'b0;
        end else if (CLK_EN) begin
            state   <= next_state;
            phase   <= next_phase;
            bit_cnt <= next_bit_cnt;
            rx_sreg <= next_rx_sreg;
            tx_sreg <= next_tx_sreg;
            addr    <= next_addr;
            waddr   <= next_waddr;
            rw      <= next_rw;
            drive   <= next_drive;
            allow   <= next_allow;
            mem_we  <= next_mem_we;
        end
    end

    // ------------------------------------------------------------------
    // storage, read data settles long before the next SCL rise
    // ------------------------------------------------------------------
    twm_mem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clk   (CLK_SYS),
        .rst_n (RESET_N),
        .ce    (CLK_EN),
        .we    (mem_we),
        .addr  (mem_we ? waddr : addr),
        .wdata (rx_sreg),
        .rdata (rdata)
    );

    // ------------------------------------------------------------------
    // link stage on SCL
    // ------------------------------------------------------------------
    logic link_drive;
    logic next_link_drive;

    // drive moves four sys edges into the high phase and then holds, so the fall
    // edge takes it cleanly; costs up to four sys cycles of SCL high time
    always_comb begin
        next_link_drive = drive;
    end

    always_ff @(negedge SCL or negedge RESET_N) begin
        if (!RESET_N) begin
            link_drive <= 1'b0;
        end else if (CLK_EN) begin
            link_drive <= next_link_drive;
        end
    end

    // never drives high and never touches SCL
    assign SDA_O  = 1'b0;
    assign SDA_OE = link_drive & allow;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_sel_mismatch;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CLK_EN && !start_ev && !stop_ev && scl_rise && state == ST_RX && phase == PH_DEV &&
         bit_cnt == `TWM_LAST_BIT && !sel_match) |=> (state == ST_IDLE && !drive);
    endproperty
    a_sel_mismatch: assert property (p_sel_mismatch) else $error("slave answered a foreign select");

    property p_drive_moves_on_edge;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        $changed(drive) |-> $past(scl_rise || start_ev || stop_ev);
    endproperty
    a_drive_moves_on_edge: assert property (p_drive_moves_on_edge) else $error("drive changed off an edge");

    property p_open_drain;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        SDA_OE |-> (SDA_O == 1'b0 && state != ST_IDLE);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("SDA driven other than low");

    property p_wp_blocks;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        mem_we |-> !$past(wp);
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("write while protected");

    property p_write_acks;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        mem_we |-> (state == ST_ACK && drive) ##1 (addr == $past(addr, 1));
    endproperty
    a_write_acks: assert property (p_write_acks) else $error("write not acknowledged");

    property p_addr_inc;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        mem_we |-> addr == AW'(waddr + `TWM_ADDR_ONE);
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address not advanced");

    property p_start_restart;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CLK_EN && start_ev) |=> (state == ST_RX && phase == PH_DEV && bit_cnt == 3'h0 && !SDA_OE);
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("START did not restart");

    property p_stop_idle;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CLK_EN && stop_ev) |=> (state == ST_IDLE && !drive) ##1 !SDA_OE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("STOP did not release the bus");

    property p_tx_release;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CLK_EN && !start_ev && !stop_ev && scl_rise && state == ST_TX && bit_cnt == `TWM_LAST_BIT)
        |=> (state == ST_MACK && !drive);
    endproperty
    a_tx_release: assert property (p_tx_release) else $error("no release for master ack");

    c_start: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) start_ev);
    c_write: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) mem_we);
    c_read_more: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
        state == ST_MACK ##1 state == ST_TX);
    c_wp_nack: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
        state == ST_RX && phase == PH_DATA && wp && scl_rise && bit_cnt == `TWM_LAST_BIT);

endmodule : twm_slave

// ===== inc/twm_defs.svh
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH

// ----------------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------------
`define TWM_MEM_AW        15
`define TWM_DATA_W        8
`define TWM_ADDR_RST      15'h0000
`define TWM_ADDR_ONE      15'h0001

// ----------------------------------------------------------------------
// slave address byte fields
// ----------------------------------------------------------------------
`define TWM_TYPE_HI       7
`define TWM_TYPE_LO       4
`define TWM_SEL_HI        3
`define TWM_SEL_LO        1
`define TWM_RW_BIT        0
`define TWM_SEL_W         3
// arbitrary value, not a real part's code
`define TWM_DEV_TYPE_DFLT 4'h5

// ----------------------------------------------------------------------
// bit counting and pin sampling
// ----------------------------------------------------------------------
`define TWM_LAST_BIT      3'h7
`define TWM_PIN_W         6
`define TWM_PIN_SDA       0
`define TWM_PIN_SCL       1
`define TWM_PIN_WP        2
`define TWM_PIN_SEL_LO    3
`define TWM_PIN_SEL_HI    5
// scl and sda rest high, so no false edge after reset
`define TWM_PIN_IDLE      6'h03

`endif

// ===== inc/twm_pkg.sv
package twm_pkg;

    // ------------------------------------------------------------------
    // bit-level engine state and byte phase
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK
    } twm_state_type;

    typedef enum logic [1:0] {
        PH_DEV,
        PH_AHI,
        PH_ALO,
        PH_DATA
    } twm_phase_type;

endpackage : twm_pkg

// ===== core/twm_mem.sv
`timescale 1ns/10ps

module twm_mem #(
    parameter int AW = 15,
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // access port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [DW-1:0] array [0:(1<<AW)-1];
    logic [DW-1:0] next_rdata;

    always_comb begin
        next_rdata = array[addr];
    end

    // no reset on the array, only on the read register
    always_ff @(posedge clk) begin
        if (ce && we) begin
            array[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= next_rdata;
        end
    end

endmodule : twm_mem

// ===== test/twm_bus_master.sv
`timescale 1ns/10ps

module twm_bus_master (
    // bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // ------------------------------------------------------------------
    // idle bus: both lines released, pulled high
    // ------------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // ------------------------------------------------------------------
    // bit and condition primitives
    // ------------------------------------------------------------------
    // master clocks every slot, acks too; sda moves only while scl low
    task automatic bit_cyc(input logic drv, output logic got);
        sda_low = ~drv;
        #31.25 scl = 1'b1;
        #62.5 got = sda;
        scl = 1'b0;
        #31.25;
    endtask : bit_cyc

    task automatic start_cond();
        sda_low = 1'b0;
        #31.25 scl = 1'b1;
        #62.5 sda_low = 1'b1;
        #62.5 scl = 1'b0;
        #31.25;
    endtask : start_cond

    // scl then stands still high until the next frame
    task automatic stop_cond();
        sda_low = 1'b1;
        #31.25 scl = 1'b1;
        #62.5 sda_low = 1'b0;
        #125;
    endtask : stop_cond

    // ------------------------------------------------------------------
    // byte transfers, msb first, ninth slot is the acknowledge
    // ------------------------------------------------------------------
    task automatic send(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], a);
        end
        bit_cyc(1'b1, a);
        ack = ~a;
    endtask : send

    task automatic recv(output logic [7:0] d, input logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, d[i]);
        end
        bit_cyc(~ack, x);
    endtask : recv

endmodule : twm_bus_master

// ===== test/tb_twm_slave.sv
`timescale 1ns/10ps

`define TWM_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_twm_slave;
    // arbitrary device type code
    localparam logic [3:0] DEV_T = 4'h6;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       clk_sys;
    logic       reset_n;
    logic       clk_en;
    logic       write_protect;
    logic [2:0] pins;
    wire        scl;
    wire        sda_low;
    wire        sda_oe;
    wire        sda_o;
    wire        sda_line;
    int         checks;
    int         n_fail;

    // wired-and with pull-up: any party pulling wins
    assign sda_line = ~(sda_low | sda_oe);

    twm_slave #(.DEV_TYPE(DEV_T)) uut (
        .CLK_SYS            (clk_sys),
        .RESET_N            (reset_n),
        .CLK_EN             (clk_en),
        .SCL                (scl),
        .SDA_I              (sda_line),
        .SDA_O              (sda_o),
        .SDA_OE             (sda_oe),
        .WRITE_PROTECT      (write_protect),
        .DEVICE_SELECT_PINS (pins)
    );

    twm_bus_master m (
        .scl     (scl),
        .sda_low (sda_low),
        .sda     (sda_line)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
        return {DEV_T, s, rd};
    endfunction : dev

    task automatic put(input logic [7:0] d, input logic exp_ack);
        logic a;
        m.send(d, a);
        `TWM_CHK(a, exp_ack)
    endtask : put

    task automatic get(input logic [7:0] exp, input logic ack);
        logic [7:0] d;
        m.recv(d, ack);
        `TWM_CHK(d, exp)
    endtask : get

    // start, write address, both memory address bytes
    task automatic seek(input logic [15:0] a);
        m.start_cond();
        put(dev(pins, 1'b0), 1'b1);
        put(a[15:8], 1'b1);
        put(a[7:0], 1'b1);
    endtask : seek

    task automatic read_cur();
        m.start_cond();
        put(dev(pins, 1'b1), 1'b1);
    endtask : read_cur

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_write_read();
        seek(16'h0123);
        put(8'hA5, 1'b1);
        put(8'h3C, 1'b1);
        m.stop_cond();
        seek(16'h0123);
        read_cur();
        get(8'hA5, 1'b1);
        get(8'h3C, 1'b0);
        m.stop_cond();
        $display("test write_read done");
    endtask : t_write_read

    task automatic t_select();
        for (int p = 0; p < 8; p++) begin
            @(negedge clk_sys);
            pins = p[2:0];
            #1;
            m.start_cond();
            put(dev(p[2:0] ^ 3'h1, 1'b0), 1'b0);
            m.start_cond();
            put({~DEV_T, p[2:0], 1'b0}, 1'b0);
            m.start_cond();
            put(dev(p[2:0], 1'b0), 1'b1);
            m.stop_cond();
        end
        // unconnected pins read as low
        @(negedge clk_sys);
        pins = 3'h0;
        #1;
        $display("test select done");
    endtask : t_select

    task automatic t_protect();
        seek(16'h0200);
        put(8'h11, 1'b1);
        m.stop_cond();
        @(negedge clk_sys);
        write_protect = 1'b1;
        #1;
        seek(16'h0200);
        put(8'h22, 1'b0);
        m.stop_cond();
        @(negedge clk_sys);
        write_protect = 1'b0;
        #1;
        // no increment after refused byte, so current address still points here
        read_cur();
        get(8'h11, 1'b0);
        m.stop_cond();
        $display("test protect done");
    endtask : t_protect

    task automatic t_wrap();
        seek(16'hFFFF);
        put(8'h5A, 1'b1);
        put(8'hC3, 1'b1);
        m.stop_cond();
        seek(16'h7FFF);
        read_cur();
        get(8'h5A, 1'b1);
        get(8'hC3, 1'b0);
        m.stop_cond();
        seek(16'h8000);
        read_cur();
        get(8'hC3, 1'b0);
        m.stop_cond();
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_abort();
        logic x;
        seek(16'h0300);
        put(8'h77, 1'b1);
        m.stop_cond();
        for (int k = 0; k < 2; k++) begin
            seek(16'h0300);
            for (int i = 0; i < 5; i++) begin
                m.bit_cyc(1'b0, x);
            end
            if (k == 1) begin
                m.stop_cond();
            end
            read_cur();
            get(8'h77, 1'b0);
            m.stop_cond();
        end
        $display("test abort done");
    endtask : t_abort

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        checks = 0;
        n_fail = 0;
        clk_en = 1'b1;
        write_protect = 1'b0;
        pins = 3'h0;
        reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        // bus steps are multiples of 1.25 ns; this offset keeps them off clk_sys edges
        #1;
        t_write_read();
        t_select();
        t_protect();
        t_wrap();
        t_abort();
        `TWM_CHK(sda_o, 1'b0)
        report_and_stop();
    end

    // a hang is cut short as a mismatch
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end

endmodule : tb_twm_slave
